/* File: uasb_pkg.sv */
// Package with register map, field layout, reset value and state types of the serial unit.
package uasb_pkg;
   localparam logic [7:0] ADDR_TX_HOLD = 8'h40;
   localparam logic [7:0] ADDR_RX_BUF = 8'h42;
   localparam logic [7:0] ADDR_IRQ_CTRL = 8'h44;
   localparam logic [7:0] ADDR_STATUS = 8'h46;
   localparam logic [7:0] ADDR_FRAME = 8'h48;
   localparam logic [7:0] ADDR_MODE = 8'h4A;
   localparam logic [7:0] ADDR_BAUD = 8'h4C;
   localparam logic [7:0] ADDR_PRESCALE = 8'h4E;
   localparam int FRS_PEN = 6;
   localparam int FRS_PSEL = 4;
   localparam int FRS_XB9 = 3;
   localparam int FRS_STP = 2;
   localparam int MODE_EXT_CLK = 0;
   localparam int MODE_ATTN = 1;
   localparam int IC_ETI = 0;
   localparam int IC_ERI = 1;
   localparam int IC_EEI = 2;
   localparam int IC_EFCI = 3;
   localparam logic [1:0] FMT_8 = 2'h0;
   localparam logic [1:0] FMT_7 = 2'h1;
   localparam logic [1:0] FMT_9 = 2'h2;
   localparam logic [1:0] FMT_LOOP = 2'h3;
   localparam logic [1:0] PAR_ODD = 2'h0;
   localparam logic [1:0] PAR_EVEN = 2'h1;
   localparam logic [1:0] PAR_MARK = 2'h2;
   typedef enum logic [1:0] {TX_IDLE = 2'b01, TX_SHIFT = 2'b10} uasb_tx_e;
   typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_DATA = 2'b10} uasb_rx_e;
   typedef struct packed {
      uasb_tx_e tx_st;
      uasb_rx_e rx_st;
      logic [7:0] tx_hold;
      logic tbe;
      logic xmip;
      logic [12:0] tx_shift;
      logic [3:0] tx_cnt;
      logic [10:0] rx_shift;
      logic [3:0] rx_cnt;
      logic [7:0] rx_buf;
      logic rbf;
      logic rb9;
      logic err;
      logic [4:0] psc;
      logic [10:0] div;
      logic [6:0] frs;
      logic [1:0] mode;
      logic [3:0] ie;
      logic dcts;
      logic cts_q;
      logic [5:0] acc;
      logic [10:0] dcnt;
      logic sclk_int;
      logic sclk_oe;
      logic sclk_q;
      logic txd;
      logic [7:0] rdata;
      logic irq_tx;
      logic irq_rx;
      logic irq_flow;
      logic rts_n;
   } uasb_state_s;
   localparam uasb_state_s STATE_RESET = '{tx_st: TX_IDLE, rx_st: RX_IDLE, tbe: 1'b1, cts_q: 1'b1,
      sclk_oe: 1'b1, txd: 1'b1, rts_n: 1'b1, default: '0};
endpackage

/* File: uasb_core.sv */
// Synchronous serial transceiver with attention filter, loop-back and two-stage baud generator.
`timescale 1ns/1ps
module uasb_core (
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_rxd,
   output logic o_txd,
   input wire logic i_serial_clock_pin,
   output logic o_serial_clock_pin,
   output logic o_serial_clock_pin_oe,
   input wire logic i_cts_n,
   output logic o_rts_n,
   output logic o_irq_tx,
   output logic o_irq_rx,
   output logic o_irq_flow
);
   uasb_pkg::uasb_state_s r;
   uasb_pkg::uasb_state_s next_r;
   logic run;
   logic ptick;
   logic btick;
   logic [5:0] sum;
   logic [5:0] tgt;
   logic lvl;
   logic tx_edge;
   logic rx_edge;
   logic cts_ok;
   logic load;
   logic [12:0] frame;
   logic [3:0] flen;
   logic [3:0] nb;
   logic nine;
   logic par_on;
   logic rx_bit;
   logic [10:0] rxs;
   logic rx_done;
   logic rx_store;
   logic [7:0] rdat;
   logic ninth;
   logic perr;
   logic wr_tx;

   // ----------------------------------------
   // Frame helpers
   // ----------------------------------------
   function automatic logic f_pbit(input logic [7:0] d, input logic [1:0] ps);
      logic p;
      case (ps)
         uasb_pkg::PAR_ODD: p = ~^d;
         uasb_pkg::PAR_EVEN: p = ^d;
         uasb_pkg::PAR_MARK: p = 1'b1;
         default: p = 1'b0;
      endcase
      return p;
   endfunction

   // Builds the whole frame, start bit at bit 0, idle ones above the last stop bit.
   function automatic logic [12:0] f_frame(input logic [7:0] d, input logic [6:0] frs);
      logic [12:0] f;
      logic p;
      f = 13'h1FFF;
      f[0] = 1'b0;
      case (frs[1:0])
         uasb_pkg::FMT_7:
         begin
            p = f_pbit({1'b0, d[6:0]}, frs[uasb_pkg::FRS_PSEL +: 2]);
            f[7:1] = d[6:0];
            f[8] = frs[uasb_pkg::FRS_PEN] ? p : 1'b1;
         end
         uasb_pkg::FMT_8:
         begin
            p = f_pbit(d, frs[uasb_pkg::FRS_PSEL +: 2]);
            f[8:1] = d;
            f[9] = frs[uasb_pkg::FRS_PEN] ? p : 1'b1;
         end
         default:
         begin
            f[8:1] = d;
            f[9] = frs[uasb_pkg::FRS_XB9];
         end
      endcase
      return f;
   endfunction

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb
   begin
      next_r = r;
      next_r.rdata = 8'h00;
      wr_tx = i_wr && (i_addr == uasb_pkg::ADDR_TX_HOLD);
      // Read side effects come first so that a hardware set in the same cycle wins.
      if (i_rd)
      begin
         case (i_addr)
            uasb_pkg::ADDR_TX_HOLD: next_r.rdata = r.tx_hold;
            uasb_pkg::ADDR_RX_BUF:
            begin
               next_r.rdata = r.rx_buf;
               next_r.rbf = 1'b0;
            end
            uasb_pkg::ADDR_IRQ_CTRL:
            begin
               next_r.rdata = {~r.cts_q, r.dcts, 2'b00, r.ie};
               next_r.dcts = 1'b0;
            end
            uasb_pkg::ADDR_STATUS:
            begin
               next_r.rdata = {3'b000, r.rb9, r.err, r.xmip, r.tbe, r.rbf};
               next_r.err = 1'b0;
            end
            uasb_pkg::ADDR_FRAME: next_r.rdata = {1'b0, r.frs};
            uasb_pkg::ADDR_MODE: next_r.rdata = {6'h00, r.mode};
            uasb_pkg::ADDR_BAUD: next_r.rdata = r.div[7:0];
            uasb_pkg::ADDR_PRESCALE: next_r.rdata = {r.psc, r.div[10:8]};
            default: next_r.rdata = 8'h00;
         endcase
      end

      // Prescaler counts in half steps: adds two per cycle, ticks at code plus one.
      run = (r.psc != 5'h00);
      tgt = {1'b0, r.psc} + 6'h01;
      sum = r.acc + 6'h02;
      ptick = 1'b0;
      if (!run)
      begin
         next_r.acc = 6'h00;
      end
      else if (sum >= tgt)
      begin
         ptick = 1'b1;
         next_r.acc = sum - tgt;
      end
      else
      begin
         next_r.acc = sum;
      end
      btick = 1'b0;
      if (ptick)
      begin
         if (r.dcnt == r.div)
         begin
            next_r.dcnt = 11'h000;
            btick = 1'b1;
         end
         else
         begin
            next_r.dcnt = r.dcnt + 11'h001;
         end
      end
      if (btick)
      begin
         next_r.sclk_int = ~r.sclk_int;
      end
      next_r.sclk_oe = ~r.mode[uasb_pkg::MODE_EXT_CLK];
      lvl = r.mode[uasb_pkg::MODE_EXT_CLK] ? i_serial_clock_pin : r.sclk_int;
      next_r.sclk_q = lvl;
      tx_edge = run && lvl && !r.sclk_q;
      rx_edge = run && !lvl && r.sclk_q;
      next_r.cts_q = i_cts_n;
      if (r.cts_q != i_cts_n)
      begin
         next_r.dcts = 1'b1;
      end
      cts_ok = !r.cts_q;

      // Transmitter.
      nine = r.frs[1];
      nb = (r.frs[1:0] == uasb_pkg::FMT_7) ? 4'h7 : (nine ? 4'h9 : 4'h8);
      par_on = r.frs[uasb_pkg::FRS_PEN] && !nine;
      flen = 4'h2 + nb + {3'b000, par_on} + {3'b000, r.frs[uasb_pkg::FRS_STP]};
      frame = f_frame(r.tx_hold, r.frs);
      load = 1'b0;
      case (r.tx_st)
         uasb_pkg::TX_IDLE:
         begin
            load = tx_edge && !r.tbe && cts_ok;
         end
         uasb_pkg::TX_SHIFT:
         begin
            if (tx_edge)
            begin
               if (r.tx_cnt != 4'h0)
               begin
                  next_r.txd = r.tx_shift[0];
                  next_r.tx_shift = {1'b1, r.tx_shift[12:1]};
                  next_r.tx_cnt = r.tx_cnt - 4'h1;
               end
               else if (!r.tbe && cts_ok)
               begin
                  load = 1'b1;
               end
               else
               begin
                  next_r.tx_st = uasb_pkg::TX_IDLE;
                  next_r.xmip = 1'b0;
               end
            end
         end
         default: next_r.tx_st = uasb_pkg::TX_IDLE;
      endcase
      if (load)
      begin
         next_r.txd = frame[0];
         next_r.tx_shift = {1'b1, frame[12:1]};
         next_r.tx_cnt = flen - 4'h1;
         next_r.tbe = 1'b1;
         next_r.xmip = 1'b1;
         next_r.tx_st = uasb_pkg::TX_SHIFT;
      end

      // Receiver.
      rx_bit = (r.frs[1:0] == uasb_pkg::FMT_LOOP) ? r.txd : i_rxd;
      rxs = r.rx_shift;
      rxs[r.rx_cnt] = rx_bit;
      rx_done = 1'b0;
      case (r.rx_st)
         uasb_pkg::RX_IDLE:
         begin
            if (rx_edge && !rx_bit)
            begin
               next_r.rx_st = uasb_pkg::RX_DATA;
               next_r.rx_cnt = 4'h0;
            end
         end
         uasb_pkg::RX_DATA:
         begin
            if (rx_edge)
            begin
               next_r.rx_shift = rxs;
               next_r.rx_cnt = r.rx_cnt + 4'h1;
               if (r.rx_cnt == nb + {3'b000, par_on})
               begin
                  rx_done = 1'b1;
                  next_r.rx_st = uasb_pkg::RX_IDLE;
               end
            end
         end
         default: next_r.rx_st = uasb_pkg::RX_IDLE;
      endcase
      rdat = (nb == 4'h7) ? {1'b0, rxs[6:0]} : rxs[7:0];
      ninth = nine && rxs[8];
      perr = par_on && (rxs[nb] != f_pbit(rdat, r.frs[uasb_pkg::FRS_PSEL +: 2]));
      rx_store = rx_done && !(r.mode[uasb_pkg::MODE_ATTN] && nine && !ninth);
      if (rx_store)
      begin
         next_r.rx_buf = rdat;
         next_r.rb9 = ninth;
         next_r.rbf = 1'b1;
         if (perr || !rx_bit || r.rbf)
         begin
            next_r.err = 1'b1;
         end
         if (r.mode[uasb_pkg::MODE_ATTN] && nine)
         begin
            next_r.mode[uasb_pkg::MODE_ATTN] = 1'b0;
         end
      end

      // Writes last: a new character or a re-armed filter is never lost.
      if (i_wr)
      begin
         case (i_addr)
            uasb_pkg::ADDR_TX_HOLD:
            begin
               next_r.tx_hold = i_wdata;
               next_r.tbe = 1'b0;
            end
            uasb_pkg::ADDR_RX_BUF: next_r.rx_buf = i_wdata;
            uasb_pkg::ADDR_IRQ_CTRL: next_r.ie = i_wdata[3:0];
            uasb_pkg::ADDR_FRAME: next_r.frs = i_wdata[6:0];
            uasb_pkg::ADDR_MODE: next_r.mode = i_wdata[1:0];
            uasb_pkg::ADDR_BAUD: next_r.div[7:0] = i_wdata;
            uasb_pkg::ADDR_PRESCALE:
            begin
               next_r.psc = i_wdata[7:3];
               next_r.div[10:8] = i_wdata[2:0];
            end
            default: next_r.psc = r.psc;
         endcase
      end
      next_r.irq_tx = next_r.tbe && next_r.ie[uasb_pkg::IC_ETI];
      next_r.irq_rx = (next_r.rbf && next_r.ie[uasb_pkg::IC_ERI])
         || (next_r.err && next_r.ie[uasb_pkg::IC_EEI]);
      next_r.irq_flow = next_r.dcts && next_r.ie[uasb_pkg::IC_EFCI];
      next_r.rts_n = next_r.tbe && !next_r.xmip;
   end

   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         r <= uasb_pkg::STATE_RESET;
      end
      else
      begin
         r <= next_r;
      end
   end

   assign o_rdata = r.rdata;
   assign o_txd = r.txd;
   assign o_serial_clock_pin = r.sclk_int;
   assign o_serial_clock_pin_oe = r.sclk_oe;
   assign o_rts_n = r.rts_n;
   assign o_irq_tx = r.irq_tx;
   assign o_irq_rx = r.irq_rx;
   assign o_irq_flow = r.irq_flow;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);

   sequence s_tx_write;
      wr_tx;
   endsequence
   sequence s_last_out_full;
      r.tx_st == uasb_pkg::TX_SHIFT && tx_edge && r.tx_cnt == 4'h0 && !r.tbe && cts_ok && !wr_tx;
   endsequence
   sequence s_last_out_empty;
      r.tx_st == uasb_pkg::TX_SHIFT && tx_edge && r.tx_cnt == 4'h0 && r.tbe && !wr_tx;
   endsequence
   sequence s_div_wrap;
      ptick && r.dcnt == r.div;
   endsequence

   property p_tx_write_clears;
      s_tx_write |=> !r.tbe && r.tx_hold == $past(i_wdata);
   endproperty
   a_tx_write_clears: assert property (p_tx_write_clears) else $error("Write left buffer empty set.");

   property p_reload;
      s_last_out_full |=> r.tbe && r.xmip && r.txd == 1'b0;
   endproperty
   a_reload: assert property (p_reload) else $error("Holding byte not moved after last stop bit.");

   property p_busy_end;
      s_last_out_empty |=> !r.xmip && r.tx_st == uasb_pkg::TX_IDLE && o_rts_n;
   endproperty
   a_busy_end: assert property (p_busy_end) else $error("Busy flag held after final bit.");

   property p_rx_store;
      rx_store |=> r.rbf && r.rx_buf == $past(rdat);
   endproperty
   a_rx_store: assert property (p_rx_store) else $error("Received character not stored.");

   property p_rx_read;
      (i_rd && i_addr == uasb_pkg::ADDR_RX_BUF && !rx_store) |=> !r.rbf;
   endproperty
   a_rx_read: assert property (p_rx_read) else $error("Buffer read did not clear full flag.");

   property p_attn_drop;
      (rx_done && r.mode[uasb_pkg::MODE_ATTN] && nine && !ninth && !i_wr) |=> r.rx_buf == $past(r.rx_buf);
   endproperty
   a_attn_drop: assert property (p_attn_drop) else $error("Filtered character reached buffer.");

   property p_attn_clear;
      (rx_store && r.mode[uasb_pkg::MODE_ATTN] && nine && !i_wr) |=> !r.mode[uasb_pkg::MODE_ATTN] && r.rb9;
   endproperty
   a_attn_clear: assert property (p_attn_clear) else $error("Address did not clear filter bit.");

   property p_power_down;
      (r.psc == 5'h00) |=> r.acc == 6'h00 && r.sclk_int == $past(r.sclk_int);
   endproperty
   a_power_down: assert property (p_power_down) else $error("Clock ran with prescaler stopped.");

   property p_div_wrap;
      s_div_wrap |=> r.dcnt == 11'h000 && r.sclk_int != $past(r.sclk_int);
   endproperty
   a_div_wrap: assert property (p_div_wrap) else $error("Divisor stage did not wrap.");

   property p_half_step;
      (r.psc == 5'h02 && ptick) ##1 (r.psc == 5'h02 && ptick) |=> (r.psc != 5'h02 || !ptick);
   endproperty
   a_half_step: assert property (p_half_step) else $error("Factor 1.5 not alternating.");

   property p_tx_irq;
      o_irq_tx == (r.tbe && r.ie[uasb_pkg::IC_ETI]);
   endproperty
   a_tx_irq: assert property (p_tx_irq) else $error("Transmit interrupt mismatch.");

   property p_flow_clear;
      (i_rd && i_addr == uasb_pkg::ADDR_IRQ_CTRL && r.cts_q == i_cts_n) |=> !r.dcts ##0 !o_irq_flow;
   endproperty
   a_flow_clear: assert property (p_flow_clear) else $error("Control read did not clear change flag.");
endmodule

/* File: uasb_remote.sv */
// Remote synchronous serial partner: captures the frames of the unit and sends frames to it.
`timescale 1ns/1ps
module uasb_remote (
   input wire logic i_sclk,
   input wire logic i_line,
   input wire logic [3:0] i_nbits,
   output logic o_line
);
   logic busy = 1'b0;
   logic [3:0] cnt = 4'h0;
   logic [8:0] sh = 9'h000;
   logic [8:0] last = 9'h000;
   logic stop_ok = 1'b0;
   int frames = 0;
   initial o_line = 1'b1;
   // Bits of the unit are taken on the falling edge, lowest bit first, ninth bit last.
   always @(negedge i_sclk)
   begin
      if (!busy)
         busy <= (i_line === 1'b0);
      else if (cnt < i_nbits)
      begin
         sh <= {i_line, sh[8:1]};
         cnt <= cnt + 4'h1;
      end
      else
      begin
         last <= sh >> (4'h9 - i_nbits);
         stop_ok <= i_line;
         frames <= frames + 1;
         busy <= 1'b0;
         cnt <= 4'h0;
      end
   end
   // Sends a whole frame, each bit launched after a rising edge, then returns the line to idle.
   task automatic send(input logic [11:0] bits, input int n);
      for (int k = 0; k < n; k++)
      begin
         @(posedge i_sclk);
         o_line <= bits[k];
      end
      @(posedge i_sclk);
      o_line <= 1'b1;
   endtask
endmodule

/* File: tb_top.sv */
// Self-checking bench of the serial unit with a remote partner on the link.
`timescale 1ns/1ps
module tb_top;
   logic i_clk_sys = 1'b0;
   logic i_rst = 1'b1;
   logic [7:0] i_addr = 8'h00;
   logic [7:0] i_wdata = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_cts_n = 1'b1;
   logic ext_clk = 1'b0;
   logic ext_run = 1'b0;
   logic [3:0] nbits = 4'h8;
   logic [7:0] o_rdata;
   logic [7:0] v;
   logic o_txd;
   logic o_sck;
   logic o_sck_oe;
   logic o_rts_n;
   logic o_irq_tx;
   logic o_irq_rx;
   logic o_irq_flow;
   logic rxd;
   logic sclk;
   int mismatches = 0;
   int cmp_count = 0;
   int cycles = 0;
   int f0;
   logic [7:0] fr [4] = '{8'h00, 8'h51, 8'h0A, 8'h05};
   logic [3:0] nb [4] = '{4'h8, 4'h8, 4'h9, 4'h7};
   logic [7:0] dt [4] = '{8'hA5, 8'h07, 8'h3C, 8'hFE};
   logic [8:0] ex [4] = '{9'h0A5, 9'h087, 9'h13C, 9'h07E};
   assign sclk = o_sck_oe ? o_sck : ext_clk;
   always #2.5 i_clk_sys = ~i_clk_sys;
   always #26 ext_clk = ext_run ? ~ext_clk : ext_clk;
   uasb_core dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
      .i_rd(i_rd), .o_rdata(o_rdata), .i_rxd(rxd), .o_txd(o_txd), .i_serial_clock_pin(sclk),
      .o_serial_clock_pin(o_sck), .o_serial_clock_pin_oe(o_sck_oe), .i_cts_n(i_cts_n), .o_rts_n(o_rts_n),
      .o_irq_tx(o_irq_tx), .o_irq_rx(o_irq_rx), .o_irq_flow(o_irq_flow));
   uasb_remote p (.i_sclk(sclk), .i_line(o_txd), .i_nbits(nbits), .o_line(rxd));
   // -----------------------------------------------------------------
   // Access and comparison tasks
   // -----------------------------------------------------------------
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk_sys);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk_sys);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask
   task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
      rd(a, v);
      chk(name, v, exp);
   endtask
   task automatic wait_st(input logic [7:0] m, input logic [7:0] e);
      for (int k = 0; k < 400; k++)
      begin
         rd(uasb_pkg::ADDR_STATUS, v);
         if ((v & m) === e)
            return;
      end
      chk("status wait", v & m, e);
   endtask
   task automatic wait_fr(input int n);
      for (int w = 0; w < 3000 && p.frames < f0 + n; w++)
         @(posedge i_clk_sys);
      chk("frame count", 12'(p.frames - f0), 12'(n));
   endtask
   task automatic settle();
      repeat (3) @(posedge i_clk_sys);
      #1;
   endtask
   // Stops the clock, loads prescaler code and divisor, and times two serial clock periods.
   task automatic baud(input logic [4:0] c, input logic [10:0] d);
      realtime t;
      wr(uasb_pkg::ADDR_PRESCALE, 8'h00);
      wr(uasb_pkg::ADDR_BAUD, d[7:0]);
      wr(uasb_pkg::ADDR_PRESCALE, {c, d[10:8]});
      @(posedge o_sck);
      t = $realtime;
      @(posedge o_sck);
      @(posedge o_sck);
      chk("clock period", 12'(int'(($realtime - t) / 5.0)), 12'(2 * (c + 1) * (d + 1)));
   endtask
   always @(posedge i_clk_sys)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         mismatches++;
         wrap_up();
      end
   end
   // -----------------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------------
   initial
   begin
      repeat (4) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      #1;
      chk("idle line", o_txd, 1'b1);
      chk("clock drive", o_sck_oe, 1'b1);
      rchk("status reset", uasb_pkg::ADDR_STATUS, 8'h02);
      rchk("irq ctrl reset", uasb_pkg::ADDR_IRQ_CTRL, 8'h00);
      rchk("frame reset", uasb_pkg::ADDR_FRAME, 8'h00);
      rchk("prescale reset", uasb_pkg::ADDR_PRESCALE, 8'h00);
      wr(8'h50, 8'h5A);
      rchk("unmapped", 8'h50, 8'h00);
      v = {7'h00, o_sck};
      repeat (64) @(posedge i_clk_sys);
      chk("stopped clock", o_sck, v[0]);
      baud(5'h02, 11'h001);
      baud(5'h03, 11'h000);
      baud(5'h1F, 11'h001);
      baud(5'h01, 11'h100);
      baud(5'h01, 11'h003);
      // Transmit held back by flow control, with transmit and flow interrupts.
      f0 = p.frames;
      wr(uasb_pkg::ADDR_IRQ_CTRL, 8'h09);
      settle();
      chk("tx irq empty", o_irq_tx, 1'b1);
      chk("flow irq idle", o_irq_flow, 1'b0);
      wr(uasb_pkg::ADDR_TX_HOLD, 8'h81);
      settle();
      chk("tx irq written", o_irq_tx, 1'b0);
      chk("request to send", o_rts_n, 1'b0);
      @(posedge i_clk_sys);
      i_cts_n <= 1'b0;
      settle();
      chk("flow irq", o_irq_flow, 1'b1);
      rchk("irq ctrl changed", uasb_pkg::ADDR_IRQ_CTRL, 8'hC9);
      rchk("irq ctrl cleared", uasb_pkg::ADDR_IRQ_CTRL, 8'h89);
      settle();
      chk("flow irq cleared", o_irq_flow, 1'b0);
      wait_fr(1);
      chk("held frame", p.last, 9'h081);
      wr(uasb_pkg::ADDR_IRQ_CTRL, 8'h00);
      // Back-to-back characters in the 8-, 7- and 9-bit frame formats.
      for (int k = 0; k < 4; k++)
      begin
         nbits <= nb[k];
         wr(uasb_pkg::ADDR_FRAME, fr[k]);
         f0 = p.frames;
         wr(uasb_pkg::ADDR_TX_HOLD, dt[k]);
         wait_st(8'h02, 8'h02);
         wr(uasb_pkg::ADDR_TX_HOLD, dt[k]);
         rchk("tx pending", uasb_pkg::ADDR_STATUS, 8'h04);
         wait_fr(2);
         chk("tx frame", p.last, ex[k]);
         chk("stop bit", p.stop_ok, 1'b1);
         wait_st(8'h06, 8'h02);
      end
      // Reception, full flag and receive interrupt.
      nbits <= 4'h8;
      wr(uasb_pkg::ADDR_FRAME, 8'h00);
      wr(uasb_pkg::ADDR_IRQ_CTRL, 8'h02);
      p.send({3'h1, 8'h5A, 1'b0}, 10);
      wait_st(8'h01, 8'h01);
      chk("rx irq", o_irq_rx, 1'b1);
      rchk("rx data", uasb_pkg::ADDR_RX_BUF, 8'h5A);
      rchk("rx emptied", uasb_pkg::ADDR_STATUS, 8'h02);
      settle();
      chk("rx irq cleared", o_irq_rx, 1'b0);
      // Missing stop bit raises the error interrupt until status is read.
      wr(uasb_pkg::ADDR_IRQ_CTRL, 8'h04);
      p.send({3'h0, 8'h11, 1'b0}, 10);
      for (int w = 0; w < 400 && o_irq_rx !== 1'b1; w++)
         @(posedge i_clk_sys);
      chk("error irq", o_irq_rx, 1'b1);
      rd(uasb_pkg::ADDR_STATUS, v);
      chk("error flag", v & 8'h08, 8'h08);
      rd(uasb_pkg::ADDR_STATUS, v);
      chk("error cleared", v & 8'h08, 8'h00);
      settle();
      chk("error irq cleared", o_irq_rx, 1'b0);
      rd(uasb_pkg::ADDR_RX_BUF, v);
      wr(uasb_pkg::ADDR_IRQ_CTRL, 8'h00);
      // Attention filter: data dropped, address kept, filter disarms itself.
      wr(uasb_pkg::ADDR_FRAME, 8'h02);
      wr(uasb_pkg::ADDR_MODE, 8'h02);
      p.send({2'h1, 1'b0, 8'h33, 1'b0}, 11);
      p.send({2'h1, 1'b1, 8'hC4, 1'b0}, 11);
      wait_st(8'h01, 8'h01);
      rchk("filter disarmed", uasb_pkg::ADDR_MODE, 8'h00);
      rchk("address status", uasb_pkg::ADDR_STATUS, 8'h13);
      rchk("address char", uasb_pkg::ADDR_RX_BUF, 8'hC4);
      p.send({2'h1, 1'b0, 8'h77, 1'b0}, 11);
      wait_st(8'h01, 8'h01);
      rchk("data after address", uasb_pkg::ADDR_RX_BUF, 8'h77);
      rchk("ninth bit clear", uasb_pkg::ADDR_STATUS, 8'h02);
      // Loop-back carries the ninth transmit bit into the receiver.
      wr(uasb_pkg::ADDR_FRAME, 8'h0B);
      wr(uasb_pkg::ADDR_TX_HOLD, 8'h96);
      wait_st(8'h01, 8'h01);
      rd(uasb_pkg::ADDR_STATUS, v);
      chk("loop ninth bit", v & 8'h11, 8'h11);
      rchk("loop data", uasb_pkg::ADDR_RX_BUF, 8'h96);
      wait_st(8'h06, 8'h02);
      // External clock on the pin; the prescaler stays nonzero.
      wr(uasb_pkg::ADDR_FRAME, 8'h00);
      wr(uasb_pkg::ADDR_MODE, 8'h01);
      settle();
      chk("clock released", o_sck_oe, 1'b0);
      ext_run = 1'b1;
      p.send({3'h1, 8'hE1, 1'b0}, 10);
      wait_st(8'h01, 8'h01);
      ext_run = 1'b0;
      rchk("external rx", uasb_pkg::ADDR_RX_BUF, 8'hE1);
      wrap_up();
   end
endmodule
